// ---- hw/lamp_dimmer_serial_config_status.sv ----
// Overview of operation
// [RULE_01] A byte with bit 7 set loads its low seven bits into the second latch.
// [RULE_02] Select high and second shutdown bit zero: reference off, coarse regulator.
// [RULE_03] Select high and second shutdown bit one: reference and regulator fully on.
// [RULE_04] A latch's shutdown bit overrides its standby bit.
// [RULE_05] Select high, second standby zero: switch off, soft-start shorted, reference kept.
// [RULE_06] Second latch both bits one with select high: lamp supply runs normally.
// [RULE_07] Second latch powers up as shutdown 1, standby 1, DAC 10000.
// [RULE_08] Select high: second latch bits 4..0 drive the DAC code.
// [RULE_09] Status bit 7 is the open-tube flag, one means no fault, resets to one.
// [RULE_10] Open-tube sense above reference clears the flag at once; it stays cleared.
// [RULE_11] The flag rearms only in shutdown or standby of the active latch.
// [RULE_12] Status bits 6 and 5 always read one.
// [RULE_13] Status bits 4..0 show the DAC code of the selected latch.
// [RULE_14] Two 7-bit latches; the select pin picks the one in control.
// [RULE_15] Only slave address 0101101 is answered.
// [RULE_16] A byte with bit 7 clear loads its low seven bits into the first latch.
// [RULE_17] Select low: first latch controls; it powers up 0, 0, DAC 10000.
// [RULE_18] Status read by read-byte; the serial link keeps working in shutdown.
// [RULE_19] Other addresses change nothing and get no acknowledge.
`timescale 1ns/1ps
module lamp_dimmer_serial_config_status
  import lamp_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic set_select_pin,
  input wire logic open_tube_sense,
  output logic reference_on,
  output logic regulator_full,
  output logic lamp_switch_en,
  output logic soft_start_short,
  output logic [4:0] dac_code,
  output logic open_tube_ok_flag
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic scl_s, sda_s, sel_s, otp_s;
  logic scl_d, sda_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  pin_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({scl_in, sda_in, set_select_pin, open_tube_sense}),
    .pin_out({scl_s, sda_s, sel_s, otp_s})
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // Configuration latches and the active set
  // ****************************************************************
  cfg_latch_t latch_first, config_latch_second, active;
  status_byte_t status_word;
  link_state_t state;
  logic [7:0] rx_shift, tx_shift;
  logic [3:0] bit_cnt;
  logic read_dir, host_ack, first_byte, drive_low;
  logic wr_commit, status_load, lamp_off_req;

  assign wr_commit = scl_fall & ~start_cond & ~stop_cond &
                     (state == ST_WR_DATA) & (bit_cnt == BITS_PER_BYTE) &
                     first_byte;

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_first <= FIRST_INIT; // [RULE_17]
      config_latch_second <= SECOND_INIT; // [RULE_07]
    end else if (wr_commit) begin
      if (rx_shift[ROUTE_BIT]) begin
        config_latch_second <= rx_shift[6:0]; // [RULE_01]
      end else begin
        latch_first <= rx_shift[6:0]; // [RULE_16]
      end
    end
  end

  // The select pin is sampled, so a swap of sets lands three edges late.
  always_ff @(posedge clk) begin
    if (rst) begin
      active <= FIRST_INIT;
    end else begin
      active <= sel_s ? config_latch_second : latch_first; // [RULE_14]
    end
  end

  assign reference_on = active.full_shutdown_n; // [RULE_02] [RULE_03]
  assign regulator_full = active.full_shutdown_n;
  assign lamp_switch_en = active.full_shutdown_n &
                          active.lamp_standby_n; // [RULE_04] [RULE_06]
  assign soft_start_short = ~lamp_switch_en; // [RULE_05]
  assign dac_code = active.dac_code; // [RULE_08] [RULE_17]
  assign lamp_off_req = ~active.full_shutdown_n | ~active.lamp_standby_n;

  // ****************************************************************
  // Open-tube flag
  // ****************************************************************
  // A trip wins over a rearm in the same cycle so no fault is lost.
  always_ff @(posedge clk) begin
    if (rst) begin
      open_tube_ok_flag <= FLAG_INIT; // [RULE_09]
    end else if (otp_s) begin
      open_tube_ok_flag <= 1'b0; // [RULE_10]
    end else if (lamp_off_req) begin
      open_tube_ok_flag <= 1'b1; // [RULE_11]
    end
  end

  assign status_word = {open_tube_ok_flag, UNUSED_STATUS,
                        active.dac_code}; // [RULE_12] [RULE_13]

  // ****************************************************************
  // Serial slave engine
  // ****************************************************************
  assign status_load = scl_fall & ~start_cond & ~stop_cond &
                       (((state == ST_ADDR_ACK) & read_dir) |
                        ((state == ST_RD_ACK) & host_ack)); // [RULE_18]

  // The engine is never gated by the lamp state, so it runs in shutdown.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      rx_shift <= '0;
      tx_shift <= '0;
      bit_cnt <= '0;
      read_dir <= 1'b0;
      host_ack <= 1'b0;
      first_byte <= 1'b0;
      drive_low <= 1'b0;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= '0;
      drive_low <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      drive_low <= 1'b0;
    end else if (scl_rise) begin
      if (state == ST_ADDR || state == ST_WR_DATA) begin
        rx_shift <= {rx_shift[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (state == ST_RD_ACK) begin
        host_ack <= ~sda_s;
      end
    end else if (scl_fall) begin
      unique case (state)
        ST_ADDR: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            if (rx_shift[7:1] == SLAVE_ADDR) begin // [RULE_15]
              state <= ST_ADDR_ACK;
              drive_low <= 1'b1;
              read_dir <= rx_shift[DIR_BIT];
              first_byte <= 1'b1;
            end else begin
              state <= ST_IGNORE; // [RULE_19]
            end
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          if (status_load) begin
            state <= ST_RD_DATA;
            tx_shift <= status_word;
            drive_low <= ~status_word[7];
            bit_cnt <= FIRST_BIT;
          end else if (state == ST_ADDR_ACK) begin
            state <= ST_WR_DATA;
            drive_low <= 1'b0;
            bit_cnt <= '0;
          end else begin
            state <= ST_IGNORE;
            drive_low <= 1'b0;
          end
        end
        ST_WR_DATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            state <= ST_WR_ACK;
            drive_low <= 1'b1;
          end
        end
        ST_WR_ACK: begin
          state <= ST_WR_DATA;
          drive_low <= 1'b0;
          bit_cnt <= '0;
          first_byte <= 1'b0;
        end
        ST_RD_DATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            state <= ST_RD_ACK;
            drive_low <= 1'b0;
          end else begin
            drive_low <= ~tx_shift[6];
            tx_shift <= {tx_shift[6:0], 1'b1};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        ST_IDLE, ST_IGNORE: begin
        end
      endcase
    end
  end

  assign sda_out = SDA_LOW;
  assign sda_oe_n = ~drive_low;

  // ****************************************************************
  // Checks
  // ****************************************************************
  second_write_a: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
    wr_commit && rx_shift[7] |=> config_latch_second == $past(rx_shift[6:0])
      && $stable(latch_first))
    else $error("Second latch not loaded from routed byte.");

  first_write_a: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
    wr_commit && !rx_shift[7] |=> latch_first == $past(rx_shift[6:0])
      && $stable(config_latch_second))
    else $error("First latch not loaded from routed byte.");

  full_shutdown_a: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
    sel_s && !config_latch_second.full_shutdown_n |=>
      !reference_on && !regulator_full && !lamp_switch_en)
    else $error("Shutdown did not turn reference and lamp off.");

  standby_only_a: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    sel_s && config_latch_second.full_shutdown_n
      && !config_latch_second.lamp_standby_n |=>
      soft_start_short && !lamp_switch_en && reference_on)
    else $error("Standby did not hold the switch off alone.");

  normal_run_a: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
    sel_s && config_latch_second.full_shutdown_n
      && config_latch_second.lamp_standby_n |=>
      lamp_switch_en && regulator_full && !soft_start_short)
    else $error("Lamp supply not running in normal mode.");

  power_up_a: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
    $past(rst) |-> config_latch_second == SECOND_INIT
      && latch_first == FIRST_INIT && open_tube_ok_flag)
    else $error("Latches or flag wrong after reset.");

  dac_select_a: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
    1'b1 |=> dac_code == ($past(sel_s) ? $past(config_latch_second.dac_code)
      : $past(latch_first.dac_code)))
    else $error("DAC code not taken from the selected latch.");

  flag_trip_a: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
    otp_s |=> !open_tube_ok_flag)
    else $error("Open-tube trip did not clear the flag.");

  flag_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    !open_tube_ok_flag && !lamp_off_req |=> !open_tube_ok_flag)
    else $error("Flag rearmed without shutdown or standby.");

  flag_rearm_a: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    !otp_s && lamp_off_req |=> open_tube_ok_flag)
    else $error("Flag not rearmed in shutdown or standby.");

  status_load_a: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
    status_load |=> tx_shift == $past(status_word)
      && tx_shift[6:5] == UNUSED_STATUS)
    else $error("Status byte loaded with wrong content.");

  foreign_addr_a: assert property (@(posedge clk) disable iff (rst) // [RULE_19]
    state == ST_IGNORE |-> sda_oe_n && !wr_commit)
    else $error("Foreign transaction was answered.");

endmodule : lamp_dimmer_serial_config_status

// ---- hw/lamp_cfg_pkg.sv ----
package lamp_cfg_pkg;

  // ****************************************************************
  // Serial link constants
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h2D;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BIT = 4'h1;
  localparam int ROUTE_BIT = 7;
  localparam int DIR_BIT = 0;
  localparam logic SDA_LOW = 1'b0;

  // ****************************************************************
  // Configuration latches and status byte
  // ****************************************************************
  typedef struct packed {
    logic full_shutdown_n;
    logic lamp_standby_n;
    logic [4:0] dac_code;
  } cfg_latch_t;

  localparam cfg_latch_t FIRST_INIT = 7'h10;
  localparam cfg_latch_t SECOND_INIT = 7'h70;
  localparam logic [1:0] UNUSED_STATUS = 2'h3;
  localparam logic FLAG_INIT = 1'b1;

  typedef struct packed {
    logic open_tube_ok_flag;
    logic [1:0] unused_ones;
    logic [4:0] dac_readback;
  } status_byte_t;

  // Gray codes along the usual path of a transaction.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_DATA = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_DATA = 3'h7,
    ST_RD_ACK = 3'h5,
    ST_IGNORE = 3'h4
  } link_state_t;

endpackage : lamp_cfg_pkg

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] stage_one;

  // ****************************************************************
  // Two flip-flops; the first one feeds only the second.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_one <= '0;
      pin_out <= '0;
    end else begin
      stage_one <= pin_in;
      pin_out <= stage_one;
    end
  end
endmodule : pin_sync

// ---- sim/smbus_host_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Host controller on the far side of the serial link
// ****************************************************************
module smbus_host_model (
  input wire logic clk,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic host_sda = 1'h1;
  // The line has a pull-up, so a released line reads high.
  assign sda = host_sda & (sda_oe_n | sda_out);
  initial scl = 1'h1;

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold

  // Each half of a bit lasts six cycles, well above what the sync needs.
  task automatic bit_io(input logic b, output logic r);
    hold(3);
    host_sda = b;
    hold(3);
    scl = 1'h1;
    hold(6);
    r = sda;
    scl = 1'h0;
  endtask : bit_io

  task automatic start_c;
    host_sda = 1'h1;
    scl = 1'h1;
    hold(6);
    host_sda = 1'h0;
    hold(6);
    scl = 1'h0;
  endtask : start_c

  task automatic stop_c;
    hold(3);
    host_sda = 1'h0;
    hold(3);
    scl = 1'h1;
    hold(6);
    host_sda = 1'h1;
    hold(6);
  endtask : stop_c

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask : byte_io

  task automatic write_cfg(input logic [6:0] a, input logic [7:0] d,
                           output logic [1:0] ack);
    logic [7:0] junk;
    logic r0, r1;
    start_c;
    byte_io({a, 1'h0}, junk);
    bit_io(1'h1, r0);
    byte_io(d, junk);
    bit_io(1'h1, r1);
    stop_c;
    ack = {~r0, ~r1};
  endtask : write_cfg

  task automatic read_status(input logic [6:0] a, output logic ack,
                             output logic [7:0] st);
    logic [7:0] junk;
    logic r0, r1;
    start_c;
    byte_io({a, 1'h1}, junk);
    bit_io(1'h1, r0);
    byte_io(8'hFF, st);
    bit_io(1'h1, r1);
    stop_c;
    ack = ~r0;
  endtask : read_status
endmodule : smbus_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module tb_top
  import lamp_cfg_pkg::*;
  ();
  logic clk = 1'h0, rst = 1'h1, sel = 1'h0, sense = 1'h0;
  logic scl, sda, sda_out, sda_oe_n, ref_on, reg_full, sw_en, ss_short;
  logic flag, flag_m = 1'h1;
  logic [4:0] dac;
  int err_count = 0, total_checks = 0, seed = 71509;
  cfg_latch_t lat0 = 7'h10, lat1 = 7'h70;
  logic [9:0] exp_q[$], obs_q[$];
  event got;

  always #2 clk = ~clk;

  lamp_dimmer_serial_config_status u_dut (.clk(clk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .set_select_pin(sel), .open_tube_sense(sense), .reference_on(ref_on),
    .regulator_full(reg_full), .lamp_switch_en(sw_en),
    .soft_start_short(ss_short), .dac_code(dac), .open_tube_ok_flag(flag));

  smbus_host_model u_host (.clk(clk), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [9:0] e, input logic [9:0] g);
    exp_q.push_back(e);
    obs_q.push_back(g);
    ->got;
  endtask : chk

  // Queues let several results posted in one time step all be compared.
  always @(got) begin
    while (obs_q.size() > 0) begin
      logic [9:0] e, g;
      e = exp_q.pop_front();
      g = obs_q.pop_front();
      total_checks++;
      if (g !== e) begin
        err_count++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
    end
  end

  function automatic logic [9:0] want(input cfg_latch_t l, input logic f);
    logic on;
    on = l.full_shutdown_n & l.lamp_standby_n;
    return {l.full_shutdown_n, l.full_shutdown_n, on, ~on, f, l.dac_code};
  endfunction : want

  task automatic look;
    cfg_latch_t l;
    logic a;
    logic [7:0] st;
    l = sel ? lat1 : lat0;
    chk(want(l, flag_m), {ref_on, reg_full, sw_en, ss_short, flag, dac});
    u_host.read_status(SLAVE_ADDR, a, st);
    chk({1'h1, 1'h0, flag_m, 2'h3, l.dac_code}, {a, 1'h0, st});
  endtask : look

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [1:0] ack;
    u_host.write_cfg(a, d, ack);
    if (a == SLAVE_ADDR && d[ROUTE_BIT]) lat1 = d[6:0];
    else if (a == SLAVE_ADDR) lat0 = d[6:0];
    chk({8'h00, (a == SLAVE_ADDR) ? 2'h3 : 2'h0}, {8'h00, ack});
  endtask : wr

  task automatic pick(input logic s);
    sel = s;
    repeat (6) @(negedge clk);
    look;
  endtask : pick

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop;
  end

  initial begin
    logic [7:0] vals[5] = '{8'hA0, 8'h35, 8'hDF, 8'h1F, 8'hE3};
    repeat (16) @(negedge clk);
    rst = 1'h0;
    repeat (8) @(negedge clk);
    pick(1'h0);
    pick(1'h1);
    for (int i = 0; i < 11; i++) begin
      wr(SLAVE_ADDR, (i < 5) ? vals[i] : 8'($random(seed)));
      pick(1'h0);
      pick(1'h1);
    end
    wr(7'h2C, 8'h80);
    pick(1'h0);
    wr(SLAVE_ADDR, 8'hFF);
    pick(1'h1);
    sense = 1'h1;
    repeat (8) @(negedge clk);
    sense = 1'h0;
    flag_m = 1'h0;
    repeat (8) @(negedge clk);
    look;
    // The host rearms the flag by commanding standby on the active latch.
    wr(SLAVE_ADDR, 8'hDF);
    flag_m = 1'h1;
    look;
    repeat (4) @(negedge clk);
    report_and_stop;
  end
endmodule : tb_top
